/* File: rtl/urh_root_hub.v */
`timescale 1ns/100ps
`include "urh_map.vh"

module urh_root_hub
(
	input wire I_CLK,
	input wire I_RST_N,
	input wire [11:0] I_AWADDR,
	input wire I_AWVALID,
	output reg O_AWREADY,
	input wire [31:0] I_WDATA,
	input wire [3:0] I_WSTRB,
	input wire I_WVALID,
	output reg O_WREADY,
	output reg [1:0] O_BRESP,
	output reg O_BVALID,
	input wire I_BREADY,
	input wire [11:0] I_ARADDR,
	input wire I_ARVALID,
	output reg O_ARREADY,
	output reg [31:0] O_RDATA,
	output reg [1:0] O_RRESP,
	output reg O_RVALID,
	input wire I_RREADY,
	input wire I_CONNECT,
	input wire I_OVERCURRENT,
	input wire I_BUS_ERROR,
	input wire I_XACT_BUSY,
	input wire I_SUSPENDED,
	input wire I_PORT_RESET_DONE,
	input wire I_PORT_RESUME_DONE,
	output reg O_PORT_POWER,
	output reg O_PORT_ENABLE,
	output reg O_RESUME_REQ,
	output reg O_RESUME_DETECTED,
	output reg O_POWER_GOOD
);

////////////////////////////////////////////////////////////////////////////
// Registers

reg psm_q;
reg nps_q;
reg ocpm_q;
reg nocp_q;
reg [7:0] potpgt_q;
reg [1:0] dev_rem_q;
reg [1:0] pmask_q;
reg drwe_q;
reg ocic_q;
reg oc_ind_prev_q;
reg pps_q;
reg pes_q;
reg csc_q;
reg pesc_q;
reg ccs_prev_q;
reg [11:0] awaddr_q;
reg aw_have_q;
reg [31:0] wdata_q;
reg w_have_q;
reg pend_q;
reg [31:0] pend_data_q;
reg [7:0] pg_units_q;
reg [16:0] pg_cyc_q;

wire ccs_raw;
wire ccs_rd;
wire oc_ind_hub;
wire wr_go;
wire wr_desc_a;
wire wr_desc_b;
wire wr_hub;
wire port_apply;
wire [31:0] pw;
wire port_ctrl;
wire glob_clr;
wire glob_set;
wire port_set;
wire port_clr;
wire power_on;
wire power_off;
wire pps_d;
wire hw_dis;
wire pes_d;
wire cs_event;
reg [31:0] rd_mux;

// Decode word address match; byte address bits 1:0 are ignored
function hit;
	input [11:0] a;
	input [11:0] off;
	begin
		hit = (a[11:2] == off[11:2]);
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Status derivation

assign ccs_raw = I_CONNECT & pps_q;
assign ccs_rd = ccs_raw | dev_rem_q[0];
// Indicator valid only under collective reporting
assign oc_ind_hub = I_OVERCURRENT & ~ocpm_q & ~nocp_q;

////////////////////////////////////////////////////////////////////////////
// Write path

assign wr_go = aw_have_q & w_have_q & ~O_BVALID;
assign wr_desc_a = wr_go & hit(awaddr_q, `URH_OFF_DESC_A);
assign wr_desc_b = wr_go & hit(awaddr_q, `URH_OFF_DESC_B);
assign wr_hub = wr_go & hit(awaddr_q, `URH_OFF_HUB_STAT);
// Port writes held back while a transaction runs
assign port_apply = pend_q & ~I_XACT_BUSY;
assign pw = port_apply ? pend_data_q : 32'h00000000;

// Mask consulted only in per-port mode
assign port_ctrl = psm_q & pmask_q[0];
assign glob_clr = wr_hub & wdata_q[`URH_HS_LPS] & ~port_ctrl;
assign glob_set = wr_hub & wdata_q[`URH_HS_LPSC] & ~port_ctrl;
assign port_set = pw[`URH_PS_PPS] & port_ctrl;
assign port_clr = pw[9] & port_ctrl;
assign power_off = glob_clr | port_clr | I_OVERCURRENT;
assign power_on = glob_set | port_set;
assign pps_d = nps_q | (power_on | (pps_q & ~power_off));

// Hardware causes of enable loss
assign hw_dis = pes_q & (I_OVERCURRENT | ~ccs_raw | ~pps_d | I_BUS_ERROR);
assign pes_d = hw_dis ? 1'b0 :
	(pw[`URH_PS_CCS] ? 1'b0 :
	(((pw[`URH_PS_PES] | I_PORT_RESET_DONE | I_PORT_RESUME_DONE) &
	ccs_raw) | pes_q));
assign cs_event = ccs_raw != ccs_prev_q;

////////////////////////////////////////////////////////////////////////////
// AXI write channel

always @(posedge I_CLK or negedge I_RST_N)
begin
	if (!I_RST_N)
	begin
		O_AWREADY <= 1'b0;
		O_WREADY <= 1'b0;
		O_BVALID <= 1'b0;
		O_BRESP <= `URH_RESP_OKAY;
		awaddr_q <= 12'h000;
		aw_have_q <= 1'b0;
		wdata_q <= 32'h00000000;
		w_have_q <= 1'b0;
	end
	else
	begin
		O_AWREADY <= ~aw_have_q & ~(I_AWVALID & O_AWREADY);
		O_WREADY <= ~w_have_q & ~(I_WVALID & O_WREADY);
		if (I_AWVALID & O_AWREADY)
		begin
			awaddr_q <= I_AWADDR;
			aw_have_q <= 1'b1;
		end
		if (I_WVALID & O_WREADY)
		begin
			wdata_q <= I_WDATA;
			w_have_q <= 1'b1;
		end
		if (wr_go)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			O_BVALID <= 1'b1;
			if (hit(awaddr_q, `URH_OFF_DESC_A) |
				hit(awaddr_q, `URH_OFF_DESC_B) |
				hit(awaddr_q, `URH_OFF_HUB_STAT) |
				hit(awaddr_q, `URH_OFF_PORT1))
				O_BRESP <= `URH_RESP_OKAY;
			else
				O_BRESP <= `URH_RESP_SLVERR;
		end
		else if (O_BVALID & I_BREADY)
			O_BVALID <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////
// Descriptor registers

always @(posedge I_CLK or negedge I_RST_N)
begin
	if (!I_RST_N)
	begin
		psm_q <= `URH_RST_PSM;
		nps_q <= `URH_RST_NPS;
		ocpm_q <= `URH_RST_PSM;
		nocp_q <= `URH_RST_NOCP;
		potpgt_q <= `URH_RST_POTPGT;
		dev_rem_q <= 2'b00;
		pmask_q <= 2'b00;
	end
	else
	begin
		if (wr_desc_a)
		begin
			psm_q <= wdata_q[`URH_DA_PSM];
			nps_q <= wdata_q[`URH_DA_NPS];
			ocpm_q <= wdata_q[`URH_DA_OCPM];
			nocp_q <= wdata_q[`URH_DA_NOCP];
			potpgt_q <= wdata_q[31:24];
		end
		if (wr_desc_b)
		begin
			dev_rem_q <= wdata_q[2:1];
			pmask_q <= wdata_q[18:17];
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Hub status, wakeup and port state

always @(posedge I_CLK or negedge I_RST_N)
begin
	if (!I_RST_N)
	begin
		drwe_q <= 1'b0;
		ocic_q <= 1'b0;
		oc_ind_prev_q <= 1'b0;
		pend_q <= 1'b0;
		pend_data_q <= 32'h00000000;
		pps_q <= 1'b0;
		pes_q <= 1'b0;
		csc_q <= 1'b0;
		pesc_q <= 1'b0;
		ccs_prev_q <= 1'b0;
		O_RESUME_REQ <= 1'b0;
		O_RESUME_DETECTED <= 1'b0;
		O_PORT_POWER <= 1'b0;
		O_PORT_ENABLE <= 1'b0;
	end
	else
	begin
		oc_ind_prev_q <= oc_ind_hub;
		if (oc_ind_hub != oc_ind_prev_q)
			ocic_q <= 1'b1;
		else if (wr_hub & wdata_q[`URH_HS_OCIC])
			ocic_q <= 1'b0;
		if (wr_hub & wdata_q[`URH_HS_DRWE])
			drwe_q <= 1'b1;
		else if (wr_hub & wdata_q[`URH_HS_CRWE])
			drwe_q <= 1'b0;
		if (wr_go & hit(awaddr_q, `URH_OFF_PORT1))
		begin
			pend_q <= 1'b1;
			pend_data_q <= wdata_q;
		end
		else if (port_apply)
			pend_q <= 1'b0;
		ccs_prev_q <= ccs_raw;
		pps_q <= pps_d;
		pes_q <= pes_d;
		O_PORT_POWER <= pps_d;
		O_PORT_ENABLE <= pes_d;
		// Set wins over a same-cycle clear
		if (cs_event | (pw[`URH_PS_PES] & ~ccs_raw))
			csc_q <= 1'b1;
		else if (pw[`URH_PS_CSC])
			csc_q <= 1'b0;
		if (hw_dis)
			pesc_q <= 1'b1;
		else if (pw[`URH_PS_PESC])
			pesc_q <= 1'b0;
		O_RESUME_REQ <= drwe_q & I_SUSPENDED & cs_event;
		O_RESUME_DETECTED <= drwe_q & I_SUSPENDED & cs_event;
	end
end

////////////////////////////////////////////////////////////////////////////
// Power-on to power-good timer

always @(posedge I_CLK or negedge I_RST_N)
begin
	if (!I_RST_N)
	begin
		pg_units_q <= 8'h00;
		pg_cyc_q <= 17'h00000;
		O_POWER_GOOD <= 1'b0;
	end
	else if (!pps_q)
	begin
		pg_units_q <= potpgt_q;
		pg_cyc_q <= 17'h00000;
		O_POWER_GOOD <= 1'b0;
	end
	else if (pg_units_q == 8'h00)
		O_POWER_GOOD <= 1'b1;
	else if (pg_cyc_q == `URH_POTPGT_UNIT_CYC - 1)
	begin
		pg_cyc_q <= 17'h00000;
		pg_units_q <= pg_units_q - 8'h01;
	end
	else
		pg_cyc_q <= pg_cyc_q + 17'h00001;
end

////////////////////////////////////////////////////////////////////////////
// Read path

always @*
begin
	rd_mux = 32'h00000000;
	if (hit(I_ARADDR, `URH_OFF_DESC_A))
	begin
		rd_mux[7:0] = `URH_DA_NPORTS;
		rd_mux[`URH_DA_PSM] = psm_q;
		rd_mux[`URH_DA_NPS] = nps_q;
		rd_mux[`URH_DA_DT] = 1'b0;
		rd_mux[`URH_DA_OCPM] = ocpm_q;
		rd_mux[`URH_DA_NOCP] = nocp_q;
		rd_mux[31:24] = potpgt_q;
	end
	else if (hit(I_ARADDR, `URH_OFF_DESC_B))
	begin
		rd_mux[2:1] = dev_rem_q;
		rd_mux[18:17] = pmask_q;
	end
	else if (hit(I_ARADDR, `URH_OFF_HUB_STAT))
	begin
		rd_mux[`URH_HS_OC_IND] = oc_ind_hub;
		rd_mux[`URH_HS_DRWE] = drwe_q;
		rd_mux[`URH_HS_OCIC] = ocic_q;
	end
	else if (hit(I_ARADDR, `URH_OFF_PORT1))
	begin
		rd_mux[`URH_PS_CCS] = ccs_rd;
		rd_mux[`URH_PS_PES] = pes_q;
		rd_mux[`URH_PS_PPS] = pps_q;
		rd_mux[`URH_PS_CSC] = csc_q;
		rd_mux[`URH_PS_PESC] = pesc_q;
	end
end

always @(posedge I_CLK or negedge I_RST_N)
begin
	if (!I_RST_N)
	begin
		O_ARREADY <= 1'b0;
		O_RVALID <= 1'b0;
		O_RDATA <= 32'h00000000;
		O_RRESP <= `URH_RESP_OKAY;
	end
	else
	begin
		O_ARREADY <= ~O_RVALID & ~(I_ARVALID & O_ARREADY);
		if (I_ARVALID & O_ARREADY)
		begin
			O_RVALID <= 1'b1;
			O_RDATA <= rd_mux;
			if (hit(I_ARADDR, `URH_OFF_DESC_A) |
				hit(I_ARADDR, `URH_OFF_DESC_B) |
				hit(I_ARADDR, `URH_OFF_HUB_STAT) |
				hit(I_ARADDR, `URH_OFF_PORT1))
				O_RRESP <= `URH_RESP_OKAY;
			else
				O_RRESP <= `URH_RESP_SLVERR;
		end
		else if (O_RVALID & I_RREADY)
			O_RVALID <= 1'b0;
	end
end

endmodule // urh_root_hub

/* File: shared/urh_map.vh */
`ifndef URH_MAP_VH
`define URH_MAP_VH
// Register byte offsets
`define URH_OFF_DESC_A 12'h548
`define URH_OFF_DESC_B 12'h54c
`define URH_OFF_HUB_STAT 12'h550
`define URH_OFF_PORT1 12'h554
// First descriptor fields
`define URH_DA_NPORTS 8'h02
`define URH_DA_PSM 8
`define URH_DA_NPS 9
`define URH_DA_DT 10
`define URH_DA_OCPM 11
`define URH_DA_NOCP 12
`define URH_DA_POTPGT_LO 24
// Hub status fields
`define URH_HS_LPS 0
`define URH_HS_OC_IND 1
`define URH_HS_DRWE 15
`define URH_HS_LPSC 16
`define URH_HS_OCIC 17
`define URH_HS_CRWE 31
// Port status fields
`define URH_PS_CCS 0
`define URH_PS_PES 1
`define URH_PS_PPS 8
`define URH_PS_CSC 16
`define URH_PS_PESC 17
// Reset values
`define URH_RST_PSM 1'b0
`define URH_RST_NPS 1'b0
`define URH_RST_NOCP 1'b0
`define URH_RST_POTPGT 8'h01
`define URH_RST_DEV_REMOVABLE 16'h0000
`define URH_RST_POWER_MASK 16'h0000
// Power-good time unit
`define URH_POTPGT_UNIT_MS 2
`define URH_CLK_KHZ 50000
`define URH_POTPGT_UNIT_CYC (`URH_POTPGT_UNIT_MS * `URH_CLK_KHZ)
// AXI responses
`define URH_RESP_OKAY 2'b00
`define URH_RESP_SLVERR 2'b10
`endif

/* File: bench/urh_port_dev.sv */
`timescale 1ns/100ps
module urh_port_dev
(
	input wire i_clk,
	output reg o_connect,
	output reg o_overcurrent,
	output reg o_bus_error,
	output reg o_xact_busy
);
	initial
	begin
		{o_connect, o_overcurrent, o_bus_error, o_xact_busy} = 4'h0;
	end
	// Line levels move just after an edge
	task automatic drive(input [3:0] v);
	begin
		@(posedge i_clk);
		{o_connect, o_overcurrent, o_bus_error, o_xact_busy} <= v;
	end
	endtask
endmodule // urh_port_dev

/* File: bench/urh_root_hub_chk.sv */
`timescale 1ns/100ps
module urh_root_hub_chk
(
	input wire I_CLK,
	input wire I_RST_N,
	input wire I_ARVALID,
	input wire O_ARREADY,
	input wire O_RVALID,
	input wire O_AWREADY,
	input wire O_WREADY,
	input wire O_BVALID,
	input wire I_CONNECT,
	input wire I_OVERCURRENT,
	input wire I_BUS_ERROR,
	input wire I_XACT_BUSY,
	input wire I_SUSPENDED,
	input wire I_PORT_RESET_DONE,
	input wire I_PORT_RESUME_DONE,
	input wire O_PORT_POWER,
	input wire O_PORT_ENABLE,
	input wire O_RESUME_REQ
);
	wire done = I_PORT_RESET_DONE | I_PORT_RESUME_DONE;
	wire calm = I_CONNECT & O_PORT_POWER & ~I_OVERCURRENT & ~I_BUS_ERROR;
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	sequence s_ar;
		I_ARVALID && O_ARREADY;
	endsequence
	sequence s_done;
		done && calm;
	endsequence
	sequence s_held;
		(I_XACT_BUSY && calm && !done) [*2];
	endsequence
	property p_rd; s_ar |=> O_RVALID; endproperty
	property p_rbusy; O_RVALID |-> !O_ARREADY; endproperty
	property p_bbusy; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
	property p_oc; $rose(I_OVERCURRENT) |-> ##[1:3] !O_PORT_ENABLE; endproperty
	property p_err; I_BUS_ERROR && !done |-> ##[1:3] !O_PORT_ENABLE; endproperty
	property p_disc; $fell(I_CONNECT) |-> ##[1:3] !O_PORT_ENABLE; endproperty
	property p_en; $rose(O_PORT_ENABLE) |-> $past(I_CONNECT); endproperty
	property p_done; s_done |-> ##[1:3] O_PORT_ENABLE; endproperty
	property p_held; s_held |-> $stable(O_PORT_ENABLE); endproperty
	property p_wake; $rose(O_RESUME_REQ) |-> $past(I_SUSPENDED); endproperty
	a_rd: assert property (p_rd)
		else $error("read answer late");
	a_rbusy: assert property (p_rbusy)
		else $error("read taken while answer open");
	a_bbusy: assert property (p_bbusy)
		else $error("write taken while answer open");
	a_oc: assert property (p_oc)
		else $error("enable kept on over-current");
	a_err: assert property (p_err)
		else $error("enable kept on bus error");
	a_disc: assert property (p_disc)
		else $error("enable kept on disconnect");
	a_en: assert property (p_en)
		else $error("enable set without device");
	a_done: assert property (p_done)
		else $error("enable not set on completion");
	a_held: assert property (p_held)
		else $error("enable changed during transaction");
	a_wake: assert property (p_wake)
		else $error("resume outside suspend");
endmodule // urh_root_hub_chk
bind urh_root_hub urh_root_hub_chk i_urh_root_hub_chk (.*);

/* File: bench/usb_root_hub_port_control_tb.sv */
`timescale 1ns/100ps
`include "urh_map.vh"
`define CHK(a, e) \
	begin \
		total_checks = total_checks + 1; \
		if ((a) !== (e)) \
		begin \
			n_errors = n_errors + 1; \
			$display("[ERR] %0t got %h want %h", $time, a, e); \
		end \
	end
module usb_root_hub_port_control_tb;
	reg clk, rst_n, aw_v, w_v, b_r, ar_v, r_r;
	reg susp, rdn, rsm;
	reg [11:0] aw_a, ar_a;
	reg [31:0] w_d, rd_d;
	reg [3:0] w_s;
	reg [1:0] rd_s, wr_s;
	wire conn, oc, berr, busy, awr, wrr, bv, arr, rv, pp, pe, rq, rdt, pg;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	integer n_errors = 0, total_checks = 0, n_wake = 0;
	localparam [11:0] P = `URH_OFF_PORT1, H = `URH_OFF_HUB_STAT;
	localparam [11:0] A = `URH_OFF_DESC_A, B = `URH_OFF_DESC_B;
	always #10 clk = ~clk;
	always @(posedge clk)
		n_wake <= n_wake + rq + rdt;
	urh_port_dev i_urh_port_dev (.i_clk(clk), .o_connect(conn),
		.o_overcurrent(oc), .o_bus_error(berr), .o_xact_busy(busy));
	urh_root_hub i_urh_root_hub (.I_CLK(clk), .I_RST_N(rst_n),
		.I_AWADDR(aw_a), .I_AWVALID(aw_v), .O_AWREADY(awr), .I_WDATA(w_d),
		.I_WSTRB(w_s), .I_WVALID(w_v), .O_WREADY(wrr), .O_BRESP(br),
		.O_BVALID(bv), .I_BREADY(b_r), .I_ARADDR(ar_a), .I_ARVALID(ar_v),
		.O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv),
		.I_RREADY(r_r), .I_CONNECT(conn), .I_OVERCURRENT(oc),
		.I_BUS_ERROR(berr), .I_XACT_BUSY(busy), .I_SUSPENDED(susp),
		.I_PORT_RESET_DONE(rdn), .I_PORT_RESUME_DONE(rsm),
		.O_PORT_POWER(pp), .O_PORT_ENABLE(pe), .O_RESUME_REQ(rq),
		.O_RESUME_DETECTED(rdt), .O_POWER_GOOD(pg));
	task automatic step(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input [11:0] a, input [31:0] d);
	begin
		aw_a <= a;
		w_d <= d;
		w_s <= 4'hf;
		aw_v <= 1;
		w_v <= 1;
		b_r <= 1;
		@(posedge clk);
		while (aw_v | w_v)
		begin
			if (awr)
				aw_v <= 0;
			if (wrr)
				w_v <= 0;
			@(posedge clk);
		end
		while (bv !== 1'h1)
			@(posedge clk);
		wr_s = br;
		b_r <= 0;
		step(2);
	end
	endtask
	task automatic rd(input [11:0] a);
	begin
		ar_a <= a;
		ar_v <= 1;
		r_r <= 1;
		@(posedge clk);
		while (arr !== 1'h1)
			@(posedge clk);
		ar_v <= 0;
		@(posedge clk);
		while (rv !== 1'h1)
			@(posedge clk);
		rd_d = rdat;
		rd_s = rr;
		r_r <= 0;
		@(posedge clk);
	end
	endtask
	task automatic ck(input [11:0] a, input [31:0] e);
	begin
		rd(a);
		`CHK(rd_d, e)
	end
	endtask
	task automatic t_desc;
	begin
		ck(A, 32'h01000002);
		wr(A, 32'h5a001f02);
		`CHK(wr_s, `URH_RESP_OKAY)
		ck(A, 32'h5a001b02);
		`CHK(pp, 1'h1)
		wr(B, 32'hffffffff);
		ck(B, 32'h00060006);
		rd(12'h000);
		`CHK(rd_s, `URH_RESP_SLVERR)
		wr(12'h000, 32'h0);
		`CHK(wr_s, `URH_RESP_SLVERR)
		wr(B, 32'h0);
		wr(A, 32'h01000002);
	end
	endtask
	task automatic t_power;
	begin
		wr(H, 32'h1);
		`CHK(pp, 1'h0)
		`CHK(pg, 1'h0)
		wr(A, 32'h00000002);
		wr(H, 32'h00010000);
		`CHK(pp, 1'h1)
		`CHK(pg, 1'h1)
		ck(H, 32'h0);
		wr(A, 32'h01000102);
		wr(B, 32'h00020000);
		wr(H, 32'h1);
		`CHK(pp, 1'h1)
		wr(B, 32'h0);
		wr(H, 32'h1);
		`CHK(pp, 1'h0)
		`CHK(pg, 1'h0)
		wr(H, 32'h00010000);
		`CHK(pp, 1'h1)
		`CHK(pg, 1'h0)
		wr(A, 32'h01000002);
	end
	endtask
	task automatic t_port;
	begin
		i_urh_port_dev.drive(4'h8);
		wr(P, 32'h2);
		`CHK(pe, 1'h1)
		ck(P, 32'h00010103);
		wr(P, 32'h00010000);
		i_urh_port_dev.drive(4'h9);
		wr(P, 32'h1);
		`CHK(pe, 1'h1)
		i_urh_port_dev.drive(4'h8);
		step(2);
		`CHK(pe, 1'h0)
		ck(P, 32'h00000101);
		rdn <= 1;
		@(posedge clk);
		rdn <= 0;
		step(2);
		`CHK(pe, 1'h1)
		i_urh_port_dev.drive(4'ha);
		i_urh_port_dev.drive(4'h8);
		step(2);
		`CHK(pe, 1'h0)
		ck(P, 32'h00020101);
		wr(P, 32'h00020000);
		rsm <= 1;
		@(posedge clk);
		rsm <= 0;
		step(2);
		`CHK(pe, 1'h1)
		i_urh_port_dev.drive(4'h0);
		step(2);
		`CHK(pe, 1'h0)
		wr(P, 32'h00030000);
		wr(P, 32'h2);
		`CHK(pe, 1'h0)
		ck(P, 32'h00010100);
		wr(B, 32'h2);
		rd(P);
		`CHK(rd_d[0], 1'h1)
		wr(B, 32'h0);
		wr(P, 32'h00010000);
	end
	endtask
	task automatic t_oc;
	begin
		i_urh_port_dev.drive(4'h8);
		wr(P, 32'h2);
		i_urh_port_dev.drive(4'hc);
		step(2);
		`CHK(pe, 1'h0)
		ck(H, 32'h00020002);
		i_urh_port_dev.drive(4'h8);
		step(2);
		wr(H, 32'h00020000);
		ck(H, 32'h0);
		wr(H, 32'h00010000);
	end
	endtask
	task automatic t_wake;
		integer k;
	begin
		wr(H, 32'h00008000);
		ck(H, 32'h00008000);
		susp <= 1;
		k = n_wake;
		i_urh_port_dev.drive(4'h0);
		step(4);
		`CHK(n_wake - k, 2)
		wr(H, 32'h80000000);
		ck(H, 32'h0);
		k = n_wake;
		i_urh_port_dev.drive(4'h8);
		step(4);
		`CHK(n_wake == k, 1'h1)
	end
	endtask
	task conclude;
	begin
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		rst_n <= 1'b0;
		{aw_v, w_v, b_r, ar_v, r_r, susp, rdn, rsm} <= 8'h00;
		aw_a <= 12'h000;
		ar_a <= 12'h000;
		w_d <= 32'h00000000;
		w_s <= 4'h0;
		step(16);
		rst_n <= 1;
		step(2);
		t_desc;
		t_power;
		t_port;
		t_oc;
		t_wake;
		conclude;
	end
	initial
	begin
		#200000;
		n_errors = n_errors + 1;
		conclude;
	end
endmodule // usb_root_hub_port_control_tb
